// [logic/tcu_pkg.sv]
// package: register map, field layout and codes of the timer/counter unit
package tcu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COUNT     = 8'h00;
  localparam logic [7:0] OFS_CMP_A     = 8'h04;
  localparam logic [7:0] OFS_CMP_B     = 8'h08;
  localparam logic [7:0] OFS_CTRL_A    = 8'h0c;
  localparam logic [7:0] OFS_CTRL_B    = 8'h10;
  localparam logic [7:0] OFS_FLAGS     = 8'h14;
  localparam logic [7:0] OFS_MASK      = 8'h18;
  // field positions
  localparam int WGM_LO_POS   = 0;  // control_a_reg[1:0]
  localparam int CS_POS       = 0;  // control_b_reg[2:0]
  localparam int WGM_HI_POS   = 3;  // control_b_reg[3]
  localparam int PRE_RST_POS  = 7;  // control_b_reg[7], self clearing
  localparam int OVF_POS      = 0;
  localparam int CMPA_POS     = 1;
  localparam int CMPB_POS     = 2;
  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  // clock select codes
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler tap widths: divisor = 2**width
  localparam int PRE_W     = 10;
  localparam int TAP8_W    = 3;
  localparam int TAP64_W   = 6;
  localparam int TAP256_W  = 8;
  localparam int TAP1K_W   = 10;
  // waveform modes
  localparam logic [2:0] WGM_NORMAL  = 3'h0;
  localparam logic [2:0] WGM_PC_FF   = 3'h1;
  localparam logic [2:0] WGM_CTC     = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PC_OCR  = 3'h5;
  localparam logic [2:0] WGM_FAST_OCR = 3'h7;
  // counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/tcu_timer.sv]
// timer/counter unit: clock select, counter, compare, flags, axi4-lite regs
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module tcu_timer
  import tcu_pkg::*;
(
  input  wire logic        core_clk,           // system clock, 100 MHz
  input  wire logic        arst_n,             // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,       // write address
  input  wire logic        s_axi_awvalid,      // write address valid
  output logic             s_axi_awready,      // write address ready
  input  wire logic [31:0] s_axi_wdata,        // write data
  input  wire logic [3:0]  s_axi_wstrb,        // write strobes
  input  wire logic        s_axi_wvalid,       // write data valid
  output logic             s_axi_wready,       // write data ready
  output logic [1:0]       s_axi_bresp,        // write response
  output logic             s_axi_bvalid,       // write response valid
  input  wire logic        s_axi_bready,       // write response ready
  input  wire logic [7:0]  s_axi_araddr,       // read address
  input  wire logic        s_axi_arvalid,      // read address valid
  output logic             s_axi_arready,      // read address ready
  output logic [31:0]      s_axi_rdata,        // read data
  output logic [1:0]       s_axi_rresp,        // read response
  output logic             s_axi_rvalid,       // read data valid
  input  wire logic        s_axi_rready,       // read data ready
  input  wire logic        external_count_pin, // asynchronous count input
  input  wire logic [2:0]  irq_ack,            // per-source service pulses
  output logic             irq_overflow,       // masked overflow request
  output logic             irq_compare_a,      // masked compare a request
  output logic             irq_compare_b,      // masked compare b request
  output logic             wave_out_a,         // toggles on compare a flag
  output logic             wave_out_b,         // toggles on compare b flag
  output logic             at_bottom,          // counter is 0x00
  output logic             at_max,             // counter is 0xff
  output logic             at_top              // counter is at top_val: compare a when mode bit 2 is set (modes 4 to 7), else 0xff
);

  logic [7:0]       count_value;
  logic [7:0]       compare_a_value;
  logic [7:0]       compare_b_value;
  logic [7:0]       control_a_reg;
  logic [7:0]       control_b_reg;
  logic [2:0]       timer_flag_reg;
  logic [2:0]       timer_mask_reg;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_go;
  logic             wr_hit;
  logic             cnt_wr;
  logic [PRE_W-1:0] pre_cnt;
  logic             pin_s1;
  logic             pin_s2;
  logic             pin_prev;
  logic             timer_tick;
  logic [2:0]       clock_select_field;
  logic [2:0]       waveform_mode_field;
  logic [7:0]       top_val;
  logic             count_up;
  logic             next_up;
  logic [7:0]       next_count;
  logic             ovf_evt;
  logic             match_a;
  logic             match_b;
  logic             match_block;
  logic [2:0]       flag_set;
  logic [2:0]       flag_clr;

  assign clock_select_field = control_b_reg[CS_POS +: 3];
  assign waveform_mode_field = {control_b_reg[WGM_HI_POS],
                                control_a_reg[WGM_LO_POS +: 2]};
  assign top_val = waveform_mode_field[2] ? compare_a_value : CNT_MAX;

  // ---------------- axi4-lite write channel ----------------
  // both address and data held until the single response is taken
  assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit = aw_addr == OFS_COUNT || aw_addr == OFS_CMP_A ||
                  aw_addr == OFS_CMP_B || aw_addr == OFS_CTRL_A ||
                  aw_addr == OFS_CTRL_B || aw_addr == OFS_FLAGS ||
                  aw_addr == OFS_MASK;
  assign cnt_wr = wr_go && w_strb[0] && aw_addr == OFS_COUNT;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_a_value <= RST_BYTE;
      compare_b_value <= RST_BYTE;
      control_a_reg   <= RST_BYTE;
      control_b_reg   <= RST_BYTE;
      timer_mask_reg  <= RST_FLAGS;
    end else begin
      control_b_reg[PRE_RST_POS] <= 1'b0;
      if (wr_go && w_strb[0]) begin
        unique case (aw_addr)
          OFS_CMP_A:  compare_a_value <= w_data[7:0];
          OFS_CMP_B:  compare_b_value <= w_data[7:0];
          OFS_CTRL_A: control_a_reg   <= w_data[7:0];
          OFS_CTRL_B: control_b_reg   <= w_data[7:0];
          OFS_MASK:   timer_mask_reg  <= w_data[2:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------- axi4-lite read channel ----------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_COUNT:  s_axi_rdata[7:0] <= count_value;
        OFS_CMP_A:  s_axi_rdata[7:0] <= compare_a_value;
        OFS_CMP_B:  s_axi_rdata[7:0] <= compare_b_value;
        OFS_CTRL_A: s_axi_rdata[7:0] <= control_a_reg;
        OFS_CTRL_B: s_axi_rdata[7:0] <= control_b_reg;
        OFS_FLAGS:  s_axi_rdata[2:0] <= timer_flag_reg;
        OFS_MASK:   s_axi_rdata[2:0] <= timer_mask_reg;
        default:    s_axi_rresp      <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- clock sources ----------------
  // free-running prescaler, only the reset bit touches it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      pre_cnt <= '0;
    else if (control_b_reg[PRE_RST_POS])
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + PRE_W'(1);
  end

  // two-stage synchroniser; the latch is replaced by a second flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_s1   <= external_count_pin;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // tick selection; external edges bypass the prescaler
  always_comb begin
    unique case (clock_select_field)
      CS_STOP:     timer_tick = 1'b0;
      CS_DIRECT:   timer_tick = 1'b1;
      CS_DIV8:     timer_tick = &pre_cnt[TAP8_W-1:0];
      CS_DIV64:    timer_tick = &pre_cnt[TAP64_W-1:0];
      CS_DIV256:   timer_tick = &pre_cnt[TAP256_W-1:0];
      CS_DIV1K:    timer_tick = &pre_cnt[TAP1K_W-1:0];
      // edge seen two to three clocks after the pin moves
      CS_EXT_FALL: timer_tick = pin_prev && !pin_s2;
      CS_EXT_RISE: timer_tick = pin_s2 && !pin_prev;
    endcase
  end

  // ---------------- counter unit ----------------
  // clear, increment or decrement per mode
  always_comb begin
    next_count = count_value;
    next_up    = count_up;
    ovf_evt    = 1'b0;
    if (timer_tick) begin
      unique case (waveform_mode_field)
        WGM_CTC: begin
          next_count = (count_value == compare_a_value) ? CNT_BOTTOM
                                                        : count_value + 8'h01;
          ovf_evt    = count_value == CNT_MAX;
        end
        WGM_FAST_FF, WGM_FAST_OCR: begin
          next_count = (count_value == top_val) ? CNT_BOTTOM
                                                : count_value + 8'h01;
          ovf_evt    = count_value == top_val;
        end
        WGM_PC_FF, WGM_PC_OCR: begin
          if (count_up && count_value == top_val)
            next_up = 1'b0;
          else if (!count_up && count_value == CNT_BOTTOM)
            next_up = 1'b1;
          next_count = next_up ? count_value + 8'h01 : count_value - 8'h01;
          // overflow at bottom in dual-slope modes
          ovf_evt    = !count_up && count_value == CNT_BOTTOM;
        end
        default: begin
          // normal mode and reserved codes wrap upward
          next_count = count_value + 8'h01;
          ovf_evt    = count_value == CNT_MAX;
        end
      endcase
    end
    // cpu write wins over any clear or count
    if (cnt_wr)
      next_count = w_data[7:0];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_value <= RST_BYTE;
      count_up    <= 1'b1;
      at_bottom   <= 1'b1;
      at_max      <= 1'b0;
      at_top      <= 1'b0;
    end else begin
      count_value <= next_count;
      count_up    <= next_up;
      at_bottom   <= next_count == CNT_BOTTOM;
      at_max      <= next_count == CNT_MAX;
      at_top      <= next_count == top_val;
    end
  end

  // ---------------- compare and flags ----------------
  // block lasts until the next tick, so a stopped timer still blocks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      match_block <= 1'b0;
    else if (cnt_wr)
      match_block <= 1'b1;
    else if (timer_tick)
      match_block <= 1'b0;
  end

  assign match_a = count_value == compare_a_value && !match_block;
  assign match_b = count_value == compare_b_value && !match_block;

  // flags set on the tick following the match
  assign flag_set[CMPA_POS] = timer_tick && match_a;
  assign flag_set[CMPB_POS] = timer_tick && match_b;
  // overflow per mode; a written counter suppresses its own tick
  assign flag_set[OVF_POS]  = ovf_evt && !cnt_wr;
  // write-one clears and service acknowledge clears
  assign flag_clr = irq_ack |
                    ((wr_go && w_strb[0] && aw_addr == OFS_FLAGS) ?
                     w_data[2:0] : 3'h0);

  // set beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      timer_flag_reg <= RST_FLAGS;
    else
      timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_overflow  <= 1'b0;
      irq_compare_a <= 1'b0;
      irq_compare_b <= 1'b0;
    end else begin
      irq_overflow  <= timer_flag_reg[OVF_POS]  && timer_mask_reg[OVF_POS];
      irq_compare_a <= timer_flag_reg[CMPA_POS] && timer_mask_reg[CMPA_POS];
      irq_compare_b <= timer_flag_reg[CMPB_POS] && timer_mask_reg[CMPB_POS];
    end
  end

  // minimal waveform: frequency-generator toggle per compare event
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      wave_out_a <= wave_out_a ^ flag_set[CMPA_POS];
      wave_out_b <= wave_out_b ^ flag_set[CMPB_POS];
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_stop_holds: assert property (
    clock_select_field == CS_STOP && !cnt_wr |=> $stable(count_value))
    else $error("counter moved with no clock selected");

  chk_direct_step: assert property (
    clock_select_field == CS_DIRECT && waveform_mode_field == WGM_NORMAL
    && !cnt_wr |=> count_value == 8'($past(count_value) + 8'h01))
    else $error("direct clock did not step counter");

  chk_div8_spacing: assert property (
    clock_select_field == CS_DIV8 && timer_tick &&
    !control_b_reg[PRE_RST_POS] |=> !timer_tick [*7])
    else $error("divide-by-8 tick spacing wrong");

  chk_rise_tick: assert property (
    clock_select_field == CS_EXT_RISE && $rose(pin_s2) |-> timer_tick)
    else $error("rising external edge gave no tick");

  chk_write_wins: assert property (
    cnt_wr |=> count_value == $past(w_data[7:0]))
    else $error("counter write lost to count");

  chk_cmp_flag: assert property (
    timer_tick && count_value == compare_a_value && !match_block
    |=> timer_flag_reg[CMPA_POS])
    else $error("compare a flag not set after match");

  chk_write_block: assert property (
    cnt_wr ##1 (timer_tick && !timer_flag_reg[CMPB_POS] && !cnt_wr)
    |=> !timer_flag_reg[CMPB_POS])
    else $error("match not blocked after counter write");

  chk_ovf_wrap: assert property (
    timer_tick && waveform_mode_field == WGM_NORMAL &&
    count_value == CNT_MAX && !cnt_wr |=> timer_flag_reg[OVF_POS]
    && count_value == CNT_BOTTOM)
    else $error("normal mode wrap missed overflow");

  chk_irq_gate: assert property (
    ##1 irq_compare_a == $past(timer_flag_reg[CMPA_POS] &&
                               timer_mask_reg[CMPA_POS]))
    else $error("compare a request not gated by mask");

endmodule // tcu_timer

// [testbench/tcu_host_model.sv]
// host side model: axi4-lite master and external count source
`timescale 1ns/100ps
module tcu_host_model (
  input  wire logic        core_clk,           // clock
  output logic [7:0]       s_axi_awaddr,       // aw addr
  output logic             s_axi_awvalid,      // aw valid
  input  wire logic        s_axi_awready,      // aw ready
  output logic [31:0]      s_axi_wdata,        // w data
  output logic [3:0]       s_axi_wstrb,        // w strobes
  output logic             s_axi_wvalid,       // w valid
  input  wire logic        s_axi_wready,       // w ready
  input  wire logic [1:0]  s_axi_bresp,        // b resp
  input  wire logic        s_axi_bvalid,       // b valid
  output logic             s_axi_bready,       // b ready
  output logic [7:0]       s_axi_araddr,       // ar addr
  output logic             s_axi_arvalid,      // ar valid
  input  wire logic        s_axi_arready,      // ar ready
  input  wire logic [31:0] s_axi_rdata,        // r data
  input  wire logic [1:0]  s_axi_rresp,        // r resp
  input  wire logic        s_axi_rvalid,       // r valid
  output logic             s_axi_rready,       // r ready
  output logic             external_count_pin, // count pulses
  output logic             hang                // a wait ran out
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    external_count_pin = 1'b0;
    hang = 1'b0;
  end
  // one transfer; released payload is inverted so stale data never matches
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge core_clk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 64);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    q = s_axi_rdata[7:0];
    resp = wr ? s_axi_bresp : s_axi_rresp;
    if (n >= 64) hang <= 1'b1;
  endtask
  task automatic toggle_pin(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      external_count_pin <= ~external_count_pin;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule // tcu_host_model

// [testbench/tb.sv]
// self-checking bench of the timer/counter unit
`timescale 1ns/100ps
module tb;
  import tcu_pkg::*;
  logic        core_clk, arst_n, hang, external_count_pin;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, at_bottom, at_max, at_top;
  logic        irq_overflow, irq_compare_a, irq_compare_b;
  logic        wave_out_a, wave_out_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  irq_ack;
  int          fail_count, checked;
  tcu_timer dut (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_count_pin, .irq_ack, .irq_overflow, .irq_compare_a,
    .irq_compare_b, .wave_out_a, .wave_out_b, .at_bottom, .at_max, .at_top);
  tcu_host_model hm (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_count_pin, .hang);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] got);
    checked++;
    if (got !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic stuck();
    $display("[ERR] wait expected done seen timeout");
    fail_count++;
    complete_run();
  endtask
  always @(posedge hang) stuck();
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] r;
    hm.xfer(1'b1, a, d, q, r);
    chk("bresp", 8'(RESP_OKAY), 8'(r));
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic [1:0] r;
    hm.xfer(1'b0, a, 8'h00, q, r);
    chk("rresp", 8'(RESP_OKAY), 8'(r));
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input string what);
    logic [7:0] q;
    rd(a, q);
    chk(what, e, q);
  endtask
  task automatic t_regs();
    logic [7:0] ofs[3] = '{OFS_COUNT, OFS_CMP_A, OFS_CMP_B};
    logic [7:0] q;
    logic [1:0] r;
    rc(OFS_FLAGS, 8'h00, "flags reset");
    rc(OFS_MASK, 8'h00, "mask reset");
    for (int i = 0; i < 3; i++) begin
      rc(ofs[i], RST_BYTE, "value reset");
      w(ofs[i], 8'h5a + 8'(i));
      rc(ofs[i], 8'h5a + 8'(i), "value readback");
    end
    w(OFS_MASK, 8'h07);
    rc(OFS_MASK, 8'h07, "mask readback");
    hm.xfer(1'b1, 8'h40, 8'h11, q, r);
    chk("unmapped bresp", 8'(RESP_SLVERR), 8'(r));
    hm.xfer(1'b0, 8'h40, 8'h00, q, r);
    chk("unmapped rresp", 8'(RESP_SLVERR), 8'(r));
    $display("regs done");
  endtask
  task automatic t_ovf();
    int n;
    w(OFS_COUNT, 8'hf0);
    w(OFS_CTRL_B, 8'(CS_DIRECT));
    n = 0;
    while (at_max !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 64) stuck();
    end
    chk("top at max", 8'h01, 8'(at_top));
    @(posedge core_clk);
    chk("max after wrap", 8'h00, 8'(at_max));
    chk("bottom after wrap", 8'h01, 8'(at_bottom));
    w(OFS_CTRL_B, 8'(CS_STOP));
    rc(OFS_FLAGS, 8'h01, "overflow flag");
    chk("irq overflow", 8'h01, 8'(irq_overflow));
    w(OFS_MASK, 8'h00);
    @(posedge core_clk);
    chk("irq masked", 8'h00, 8'(irq_overflow));
    irq_ack <= 3'h1;
    @(posedge core_clk);
    irq_ack <= 3'h0;
    rc(OFS_FLAGS, 8'h00, "flag after service");
    $display("overflow done");
  endtask
  task automatic t_presc();
    int dv[4] = '{8, 64, 256, 1024};
    for (int i = 0; i < 4; i++) begin
      w(OFS_CTRL_B, 8'(CS_STOP));
      w(OFS_COUNT, 8'h00);
      // stopped while the prescaler restarts, so no stray first tick
      w(OFS_CTRL_B, 8'h80);
      w(OFS_CTRL_B, 8'(CS_DIV8 + 3'(i)));
      repeat (2 * dv[i] + dv[i] / 2 - 2) @(posedge core_clk);
      rc(OFS_COUNT, 8'h02, "prescaled count");
    end
    w(OFS_CTRL_B, 8'(CS_STOP));
    w(OFS_COUNT, 8'h33);
    repeat (20) @(posedge core_clk);
    rc(OFS_COUNT, 8'h33, "stopped count");
    $display("prescaler done");
  endtask
  task automatic t_ext();
    w(OFS_COUNT, 8'h00);
    w(OFS_CTRL_B, 8'(CS_EXT_RISE));
    hm.toggle_pin(5);
    rc(OFS_COUNT, 8'h03, "rising count");
    w(OFS_COUNT, 8'h00);
    w(OFS_CTRL_B, 8'(CS_EXT_FALL));
    hm.toggle_pin(5);
    rc(OFS_COUNT, 8'h03, "falling count");
    w(OFS_CTRL_B, 8'(CS_STOP));
    $display("external done");
  endtask
  task automatic t_cmp();
    logic [7:0] q;
    logic       wa;
    w(OFS_CMP_A, 8'h10);
    w(OFS_CMP_B, 8'h20);
    w(OFS_COUNT, 8'h0e);
    w(OFS_FLAGS, 8'h07);
    wa = wave_out_a;
    w(OFS_CTRL_B, 8'(CS_DIRECT));
    w(OFS_CTRL_B, 8'(CS_STOP));
    rc(OFS_FLAGS, 8'h02, "compare a flag");
    chk("wave a", 8'(!wa), 8'(wave_out_a));
    w(OFS_FLAGS, 8'h02);
    rc(OFS_FLAGS, 8'h00, "flag write one");
    // count equal to compare b before the first tick
    w(OFS_COUNT, 8'h20);
    w(OFS_CTRL_B, 8'(CS_DIRECT));
    w(OFS_COUNT, 8'h80);
    w(OFS_CTRL_B, 8'(CS_STOP));
    rc(OFS_FLAGS, 8'h00, "blocked match");
    rd(OFS_COUNT, q);
    chk("count write", 8'h10, 8'(q[7:3]));
    w(OFS_CMP_A, 8'h05);
    // ctc, fast up to compare a, dual slope up to compare a
    for (int m = 0; m < 3; m++) begin
      w(OFS_COUNT, 8'h00);
      w(OFS_CTRL_A, m == 0 ? 8'h02 : (m == 1 ? 8'h03 : 8'h01));
      w(OFS_CTRL_B, m ? 8'h09 : 8'h01);
      for (int k = 0; k < 6; k++) begin
        rd(OFS_COUNT, q);
        chk("count under top", 8'h01, 8'(q <= 8'h05));
      end
      w(OFS_CTRL_B, 8'(CS_STOP));
    end
    w(OFS_CTRL_A, 8'h00);
    $display("compare done");
  endtask
  initial begin
    arst_n = 1'b0;
    irq_ack = 3'h0;
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_ovf();
    t_presc();
    t_ext();
    t_cmp();
    complete_run();
  end
endmodule // tb
